// >>> inc/uaf_pkg.sv
/*
 uaf_pkg: register map, field positions, reset values, timing counts,
 state codes, carrier structs and lookup tables for one uart channel
 with 16-entry fifos and automatic rts/cts flow control.
 assumes: one clock domain; the sampling tick (16x/8x/4x) comes from
 an outside baud generator as a one-cycle pulse on the same clock.
*/
// Functional notes
// - bit lasts 16, 8 or 4 ticks
// - mode 00=16x, 01=8x, 10=4x
// - start, data lsb first, parity, stop
// - fifo mode: each data write pushes
// - no fifo: holding/shifter empty flags
// - tx empty interrupt gated by enable bit1
// - fifo mode: holding empty when fifo empty
// - fifo mode: tx interrupt below trigger
// - shifter empty needs fifo and shifter empty
// - start validated at half bit, else dropped
// - mid-bit sampling, errors in status 2-4
// - rx fifo: 16 by 11 bits
// - data read pops, tags follow head
// - rx ready interrupt, gated by enable bit0
// - timeout after 4 chars plus 12 bits
// - word length 5 to 8 bits
// - auto rts needs feature and modem bit
// - rts rising sets source bit5 if enabled
// - rts off/on thresholds per trigger
// - receiver keeps storing until fifo full
// - auto cts gates transmitter
// - cts rising sets source bit5 if enabled
// - cts stops after current stop bit
package uaf_pkg;

	// ==========================================================
	// register map: word index, byte address is four times it
	typedef logic [3:0] uaf_addr_type;
	localparam uaf_addr_type ADR_DATA = 4'h0;
	localparam uaf_addr_type ADR_IEN = 4'h1;
	localparam uaf_addr_type ADR_ISRC = 4'h2;
	localparam uaf_addr_type ADR_FCTL = 4'h3;
	localparam uaf_addr_type ADR_LCTL = 4'h4;
	localparam uaf_addr_type ADR_MCTL = 4'h5;
	localparam uaf_addr_type ADR_LSTAT = 4'h6;
	localparam uaf_addr_type ADR_EFEAT = 4'h7;
	localparam uaf_addr_type ADR_SMPL = 4'h8;

	// ==========================================================
	// field positions
	localparam int IEN_RX = 0;
	localparam int IEN_TX = 1;
	localparam int IEN_RTS = 6;
	localparam int IEN_CTS = 7;
	localparam int FCTL_EN = 0;
	localparam int FCTL_RXCLR = 1;
	localparam int FCTL_TXCLR = 2;
	localparam int FCTL_TXTRIG = 4;
	localparam int FCTL_RXTRIG = 6;
	localparam int LCTL_STOP2 = 2;
	localparam int LCTL_PEN = 3;
	localparam int LCTL_EVEN = 4;
	localparam int MCTL_RTS = 1;
	localparam int EFEAT_ENH = 4;
	localparam int EFEAT_ARTS = 6;
	localparam int EFEAT_ACTS = 7;
	localparam int SMPL_MODE = 4;

	// ==========================================================
	// reset values and timing counts
	localparam logic [7:0] CFG_BYTE_RST = 8'h00;
	localparam logic [1:0] SMP_16X = 2'b00;
	localparam logic [1:0] SMP_8X = 2'b01;
	localparam logic [1:0] SMP_4X = 2'b10;
	localparam logic [3:0] BIT_LAST_16 = 4'hF;
	localparam logic [3:0] BIT_LAST_8 = 4'h7;
	localparam logic [3:0] BIT_LAST_4 = 4'h3;
	localparam logic [3:0] HALF_LAST_16 = 4'h7;
	localparam logic [3:0] HALF_LAST_8 = 4'h3;
	localparam logic [3:0] HALF_LAST_4 = 4'h1;
	localparam logic [7:0] TO_CHARS = 8'h04;
	localparam logic [7:0] TO_EXTRA_BITS = 8'h0C;
	// index: trigger select 0..3 = levels 1, 4, 8, 14
	localparam logic [4:0] TRIG_LVL [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
	localparam logic [4:0] RTS_HI [4] = '{5'h04, 5'h08, 5'h0E, 5'h0E};
	localparam logic [4:0] RTS_LO [4] = '{5'h00, 5'h01, 5'h04, 5'h08};

	// ==========================================================
	// states and carriers
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_START = 3'b001,
		ST_DATA = 3'b010,
		ST_PAR = 3'b011,
		ST_STOP = 3'b100
	} uaf_ser_state_type;

	typedef struct packed {
		logic brk;
		logic frm;
		logic perr;
		logic [7:0] data;
	} uaf_rx_entry_type;

	typedef struct packed {
		logic [7:0] ien;
		logic [7:0] fctl;
		logic [7:0] lctl;
		logic [7:0] mctl;
		logic [7:0] efeat;
		logic [7:0] smpl;
	} uaf_cfg_type;

	function automatic logic [3:0] bit_last(input logic [1:0] m);
		case (m)
			SMP_8X: bit_last = BIT_LAST_8;
			SMP_4X: bit_last = BIT_LAST_4;
			default: bit_last = BIT_LAST_16;
		endcase
	endfunction

	function automatic logic [3:0] half_last(input logic [1:0] m);
		case (m)
			SMP_8X: half_last = HALF_LAST_8;
			SMP_4X: half_last = HALF_LAST_4;
			default: half_last = HALF_LAST_16;
		endcase
	endfunction

	// start + data + parity + stop(s), times four, plus extra bits
	function automatic logic [7:0] to_limit(input logic [7:0] lc);
		logic [7:0] ch;
		ch = 8'h07 + {6'h00, lc[1:0]} + {7'h00, lc[LCTL_PEN]}
			+ {7'h00, lc[LCTL_STOP2]};
		to_limit = 8'(ch * TO_CHARS) + TO_EXTRA_BITS;
	endfunction

endpackage

// >>> rtl/uaf_fifo.sv
/*
 uaf_fifo: synchronous fifo with fill count, used for both the
 transmit and receive paths.
 assumes: depth is a power of two; push when full and pop when empty
 are ignored; clear empties it in one cycle.
*/
module uaf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	localparam int AW = $clog2(DEPTH),
	localparam int CW = AW + 1
) (
	// system
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic clr_in,
	// write side
	input wire logic push_in,
	input wire logic [WIDTH-1:0] data_in,
	// read side
	input wire logic pop_in,
	output logic [WIDTH-1:0] data_out,
	// status
	output logic [CW-1:0] count_out,
	output logic full_out,
	output logic empty_out
);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic do_push, do_pop;

	assign full_out = cnt_q == CW'(DEPTH);
	assign empty_out = cnt_q == '0;
	assign count_out = cnt_q;
	assign data_out = mem_q[rd_q];
	assign do_push = push_in && !full_out;
	assign do_pop = pop_in && !empty_out;

	always_comb begin
		wr_d = wr_q;
		rd_d = rd_q;
		cnt_d = cnt_q;
		if (clr_in) begin
			wr_d = '0;
			rd_d = '0;
			cnt_d = '0;
		end else begin
			if (do_push)
				wr_d = wr_q + AW'(1);
			if (do_pop)
				rd_d = rd_q + AW'(1);
			if (do_push && !do_pop)
				cnt_d = cnt_q + CW'(1);
			else if (do_pop && !do_push)
				cnt_d = cnt_q - CW'(1);
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
		if (do_push && !clr_in)
			mem_q[wr_q] <= data_in;
	end
endmodule // uaf_fifo

// >>> rtl/uaf_top.sv
/*
 uaf_top: one uart channel with transmit and receive fifos, automatic
 rts/cts flow control and an avalon-mm register slave.
 assumes: samp_tick_in is a one-cycle pulse at the 16x/8x/4x rate from
 an outside baud generator on clk_in; rx_in and cts_n_in are pins.
*/
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
module uaf_top #(
	parameter int DEPTH = 16
) (
	// system
	input wire logic clk_in,
	input wire logic rst_n_in,
	// avalon-mm slave
	input wire uaf_pkg::uaf_addr_type avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// sampling clock enable
	input wire logic samp_tick_in,
	// serial line
	input wire logic rx_in,
	input wire logic cts_n_in,
	output logic tx_out,
	output logic rts_n_out,
	output logic irq_out
);
	import uaf_pkg::*;
	localparam int CW = $clog2(DEPTH) + 1;

	// ==========================================================
	// pin synchronisers
	logic rx_m_q, rx_s_q, rx_p_q, cts_m_q, cts_s_q, cts_p_q;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			rx_m_q <= 1'b1;
			rx_s_q <= 1'b1;
			rx_p_q <= 1'b1;
			cts_m_q <= 1'b1;
			cts_s_q <= 1'b1;
			cts_p_q <= 1'b1;
		end else begin
			rx_m_q <= rx_in;
			rx_s_q <= rx_m_q;
			rx_p_q <= rx_s_q;
			cts_m_q <= cts_n_in;
			cts_s_q <= cts_m_q;
			cts_p_q <= cts_s_q;
		end
	end

	// ==========================================================
	// bus slave and configuration
	uaf_cfg_type cfg_q, cfg_d;
	logic ack_q, ack_d, wait_q;
	logic [31:0] rdata_q, rdata_d;
	logic [7:0] wd, rd_mux, isr_v, lsr_v;
	logic wr, rd, rf_pop, rd_isr, rd_lsr, wr_fctl, tf_clr, rf_clr;
	logic fifo_en, pen, stop2, even, tf_push;
	logic [1:0] mode, wl;
	logic [3:0] blast, hlast;
	logic [7:0] dmask;

	// fifo wires
	logic [7:0] tf_data;
	logic [CW-1:0] tf_cnt, rf_cnt;
	logic tf_full, tf_empty, tf_pop, rf_full, rf_empty, rf_push;
	uaf_rx_entry_type rf_head, rf_in;

	assign wd = avs_writedata_in[7:0];
	assign fifo_en = cfg_q.fctl[FCTL_EN];
	assign pen = cfg_q.lctl[LCTL_PEN];
	assign stop2 = cfg_q.lctl[LCTL_STOP2];
	assign even = cfg_q.lctl[LCTL_EVEN];
	assign wl = cfg_q.lctl[1:0];
	assign mode = cfg_q.smpl[SMPL_MODE+:2];
	assign blast = bit_last(mode);
	assign hlast = half_last(mode);
	assign dmask = 8'hFF >> ~wl;
	// a request is answered one cycle after it is seen, acted on then
	assign wr = avs_write_in && ack_q && avs_byteenable_in[0];
	assign rd = avs_read_in && ack_q;
	assign rf_pop = rd && avs_address_in == ADR_DATA;
	assign rd_isr = rd && avs_address_in == ADR_ISRC;
	assign rd_lsr = rd && avs_address_in == ADR_LSTAT;
	assign wr_fctl = wr && avs_address_in == ADR_FCTL;
	// mode change flushes both fifos so no stale bytes cross over
	assign tf_clr = wr_fctl &&
		(wd[FCTL_TXCLR] || wd[FCTL_EN] != fifo_en);
	assign rf_clr = wr_fctl &&
		(wd[FCTL_RXCLR] || wd[FCTL_EN] != fifo_en);
	// one byte accepted without fifo, sixteen with
	assign tf_push = wr && avs_address_in == ADR_DATA &&
		(fifo_en ? !tf_full : tf_empty);

	always_comb begin
		case (avs_address_in)
			ADR_DATA: rd_mux = rf_head.data;
			ADR_IEN: rd_mux = cfg_q.ien;
			ADR_ISRC: rd_mux = isr_v;
			ADR_FCTL: rd_mux = cfg_q.fctl;
			ADR_LCTL: rd_mux = cfg_q.lctl;
			ADR_MCTL: rd_mux = cfg_q.mctl;
			ADR_LSTAT: rd_mux = lsr_v;
			ADR_EFEAT: rd_mux = cfg_q.efeat;
			ADR_SMPL: rd_mux = cfg_q.smpl;
			default: rd_mux = 8'h00;
		endcase
	end

	always_comb begin
		ack_d = (avs_read_in || avs_write_in) && !ack_q;
		rdata_d = ack_d ? {24'h0000_00, rd_mux} : rdata_q;
		cfg_d = cfg_q;
		if (wr) begin
			case (avs_address_in)
				ADR_IEN: begin
					// flow interrupt enables lock until enhanced mode
					cfg_d.ien[5:0] = wd[5:0];
					if (cfg_q.efeat[EFEAT_ENH])
						cfg_d.ien[7:6] = wd[7:6];
				end
				ADR_FCTL: cfg_d.fctl = {wd[7:4], 3'b000, wd[0]};
				ADR_LCTL: cfg_d.lctl = wd;
				ADR_MCTL: cfg_d.mctl = wd;
				ADR_EFEAT: cfg_d.efeat = wd;
				ADR_SMPL: cfg_d.smpl = wd;
				default: cfg_d = cfg_q;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			cfg_q <= {6{CFG_BYTE_RST}};
			ack_q <= 1'b0;
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else begin
			cfg_q <= cfg_d;
			ack_q <= ack_d;
			wait_q <= !ack_d;
			rdata_q <= rdata_d;
		end
	end

	// ==========================================================
	// fifos
	uaf_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_txf (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .clr_in(tf_clr),
		.push_in(tf_push), .data_in(wd), .pop_in(tf_pop),
		.data_out(tf_data), .count_out(tf_cnt),
		.full_out(tf_full), .empty_out(tf_empty)
	);

	// eleven bits wide: data plus three error tags
	uaf_fifo #(.WIDTH(11), .DEPTH(DEPTH)) u_rxf (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .clr_in(rf_clr),
		.push_in(rf_push), .data_in(rf_in), .pop_in(rf_pop),
		.data_out(rf_head), .count_out(rf_cnt),
		.full_out(rf_full), .empty_out(rf_empty)
	);

	// ==========================================================
	// transmitter
	uaf_ser_state_type tx_st_q, tx_st_d;
	logic [3:0] tx_cnt_q, tx_cnt_d;
	logic [2:0] tx_idx_q, tx_idx_d;
	logic [7:0] tx_sh_q, tx_sh_d;
	logic tx_par_q, tx_par_d, tx_q, tx_d, tx_end;

	assign tx_end = samp_tick_in && tx_cnt_q == blast;

	always_comb begin
		tx_st_d = tx_st_q;
		tx_idx_d = tx_idx_q;
		tx_sh_d = tx_sh_q;
		tx_par_d = tx_par_q;
		tx_cnt_d = tx_cnt_q;
		tf_pop = 1'b0;
		if (tx_st_q != ST_IDLE && samp_tick_in)
			tx_cnt_d = tx_end ? 4'h0 : tx_cnt_q + 4'h1;
		case (tx_st_q)
			ST_IDLE: begin
				// cts only looked at between characters
				if (!tf_empty &&
					!(cfg_q.efeat[EFEAT_ACTS] && cts_s_q)) begin
					tf_pop = 1'b1;
					tx_st_d = ST_START;
					tx_cnt_d = 4'h0;
					tx_sh_d = tf_data;
					tx_par_d = (^(tf_data & dmask)) ^ !even;
				end
			end
			ST_START: begin
				if (tx_end) begin
					tx_st_d = ST_DATA;
					tx_idx_d = 3'h0;
				end
			end
			ST_DATA: begin
				if (tx_end) begin
					tx_sh_d = {1'b0, tx_sh_q[7:1]};
					tx_idx_d = tx_idx_q + 3'h1;
					if (tx_idx_q == {1'b1, wl}) begin
						tx_idx_d = 3'h0;
						tx_st_d = pen ? ST_PAR : ST_STOP;
					end
				end
			end
			ST_PAR: begin
				if (tx_end)
					tx_st_d = ST_STOP;
			end
			ST_STOP: begin
				if (tx_end) begin
					if (stop2 && tx_idx_q == 3'h0)
						tx_idx_d = 3'h1;
					else
						tx_st_d = ST_IDLE;
				end
			end
			default: tx_st_d = ST_IDLE;
		endcase
		case (tx_st_d)
			ST_START: tx_d = 1'b0;
			ST_DATA: tx_d = tx_sh_d[0];
			ST_PAR: tx_d = tx_par_d;
			default: tx_d = 1'b1;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			tx_st_q <= ST_IDLE;
			tx_cnt_q <= 4'h0;
			tx_idx_q <= 3'h0;
			tx_sh_q <= 8'h00;
			tx_par_q <= 1'b0;
			tx_q <= 1'b1;
		end else begin
			tx_st_q <= tx_st_d;
			tx_cnt_q <= tx_cnt_d;
			tx_idx_q <= tx_idx_d;
			tx_sh_q <= tx_sh_d;
			tx_par_q <= tx_par_d;
			tx_q <= tx_d;
		end
	end

	// ==========================================================
	// receiver
	uaf_ser_state_type rx_st_q, rx_st_d;
	logic [3:0] rx_cnt_q, rx_cnt_d;
	logic [2:0] rx_idx_q, rx_idx_d;
	logic [7:0] rx_sh_q, rx_sh_d;
	logic rx_pb_q, rx_pb_d, rx_end, rx_done, rx_ok, ovr_set;

	assign rx_end = samp_tick_in && rx_cnt_q == blast;
	assign rf_in.data = rx_sh_q >> ~wl;
	assign rf_in.perr = pen && (rx_pb_q != ((^rf_in.data) ^ !even));
	assign rf_in.frm = !rx_s_q;
	assign rf_in.brk = !rx_s_q && rf_in.data == 8'h00 &&
		!(pen && rx_pb_q);
	assign rx_done = rx_st_q == ST_STOP && rx_end;
	// full fifo refuses; flow control does not stop the receiver
	assign rx_ok = fifo_en ? !rf_full : rf_empty;
	assign rf_push = rx_done && rx_ok;
	assign ovr_set = rx_done && !rx_ok;

	always_comb begin
		rx_st_d = rx_st_q;
		rx_idx_d = rx_idx_q;
		rx_sh_d = rx_sh_q;
		rx_pb_d = rx_pb_q;
		rx_cnt_d = rx_cnt_q;
		if (rx_st_q != ST_IDLE && samp_tick_in)
			rx_cnt_d = rx_end ? 4'h0 : rx_cnt_q + 4'h1;
		case (rx_st_q)
			ST_IDLE: begin
				if (rx_p_q && !rx_s_q) begin
					rx_st_d = ST_START;
					rx_cnt_d = 4'h0;
				end
			end
			ST_START: begin
				// a glitch gone by mid start bit is no character
				if (samp_tick_in && rx_cnt_q == hlast) begin
					rx_cnt_d = 4'h0;
					rx_idx_d = 3'h0;
					rx_st_d = rx_s_q ? ST_IDLE : ST_DATA;
				end
			end
			ST_DATA: begin
				if (rx_end) begin
					rx_sh_d = {rx_s_q, rx_sh_q[7:1]};
					rx_idx_d = rx_idx_q + 3'h1;
					if (rx_idx_q == {1'b1, wl})
						rx_st_d = pen ? ST_PAR : ST_STOP;
				end
			end
			ST_PAR: begin
				if (rx_end) begin
					rx_pb_d = rx_s_q;
					rx_st_d = ST_STOP;
				end
			end
			ST_STOP: begin
				if (rx_end)
					rx_st_d = ST_IDLE;
			end
			default: rx_st_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			rx_st_q <= ST_IDLE;
			rx_cnt_q <= 4'h0;
			rx_idx_q <= 3'h0;
			rx_sh_q <= 8'h00;
			rx_pb_q <= 1'b0;
		end else begin
			rx_st_q <= rx_st_d;
			rx_cnt_q <= rx_cnt_d;
			rx_idx_q <= rx_idx_d;
			rx_sh_q <= rx_sh_d;
			rx_pb_q <= rx_pb_d;
		end
	end

	// ==========================================================
	// status, interrupts, timeout and flow control
	logic ovr_q, ovr_d, fc_q, fc_d, off_q, off_d, rts_q, rts_d;
	logic irq_q, irq_d, arts, to_hit, int_rx, int_tx, int_to;
	logic [7:0] to_cnt_q, to_cnt_d, to_lim;
	logic [3:0] to_sub_q, to_sub_d;
	logic [1:0] rsel, tsel;

	assign rsel = cfg_q.fctl[FCTL_RXTRIG+:2];
	assign tsel = cfg_q.fctl[FCTL_TXTRIG+:2];
	assign arts = cfg_q.efeat[EFEAT_ARTS] && cfg_q.mctl[MCTL_RTS];
	assign to_lim = to_limit(cfg_q.lctl);
	assign to_hit = !rf_empty && to_cnt_q == to_lim;
	assign int_rx = cfg_q.ien[IEN_RX] && (fifo_en ?
		rf_cnt >= CW'(TRIG_LVL[rsel]) : !rf_empty);
	assign int_to = cfg_q.ien[IEN_RX] && to_hit;
	assign int_tx = cfg_q.ien[IEN_TX] && (fifo_en ?
		tf_cnt < CW'(TRIG_LVL[tsel]) : tf_empty);
	assign isr_v = {2'b00, fc_q, 1'b0, int_to, int_rx, int_tx,
		!(fc_q || int_to || int_rx || int_tx)};
	assign lsr_v = {1'b0, tf_empty && tx_st_q == ST_IDLE, tf_empty,
		rf_head.brk && !rf_empty, rf_head.frm && !rf_empty,
		rf_head.perr && !rf_empty, ovr_q, !rf_empty};

	always_comb begin
		to_cnt_d = to_cnt_q;
		to_sub_d = to_sub_q;
		if (rf_empty || rf_push || rf_pop) begin
			to_cnt_d = 8'h00;
			to_sub_d = 4'h0;
		end else if (samp_tick_in) begin
			to_sub_d = to_sub_q == blast ? 4'h0 : to_sub_q + 4'h1;
			if (to_sub_q == blast && to_cnt_q != to_lim)
				to_cnt_d = to_cnt_q + 8'h01;
		end
		// hysteresis: hold between the two thresholds
		off_d = off_q;
		if (!arts)
			off_d = 1'b0;
		else if (rf_cnt >= CW'(RTS_HI[rsel]))
			off_d = 1'b1;
		else if (rf_cnt <= CW'(RTS_LO[rsel]))
			off_d = 1'b0;
		rts_d = !cfg_q.mctl[MCTL_RTS] || off_d;
		// new events win over the read that clears
		ovr_d = ovr_set || (ovr_q && !rd_lsr);
		fc_d = (cfg_q.efeat[EFEAT_ENH] &&
			((cfg_q.ien[IEN_RTS] && rts_d && !rts_q) ||
			(cfg_q.ien[IEN_CTS] && cts_s_q && !cts_p_q))) ||
			(fc_q && !rd_isr);
		irq_d = !isr_v[0];
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			ovr_q <= 1'b0;
			fc_q <= 1'b0;
			off_q <= 1'b0;
			rts_q <= 1'b1;
			irq_q <= 1'b0;
			to_cnt_q <= 8'h00;
			to_sub_q <= 4'h0;
		end else begin
			ovr_q <= ovr_d;
			fc_q <= fc_d;
			off_q <= off_d;
			rts_q <= rts_d;
			irq_q <= irq_d;
			to_cnt_q <= to_cnt_d;
			to_sub_q <= to_sub_d;
		end
	end

	assign avs_readdata_out = rdata_q;
	assign avs_waitrequest_out = wait_q;
	assign tx_out = tx_q;
	assign rts_n_out = rts_q;
	assign irq_out = irq_q;

	// ==========================================================
	// assertions
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	property p_bitlen;
		(tx_st_q == ST_START && tx_end) |=> tx_st_q == ST_DATA;
	endproperty
	a_bitlen: assert property (p_bitlen)
		else $error("start bit did not end after one bit time");

	property p_mode4x;
		(mode == SMP_4X) |-> blast == 4'h3 && hlast == 4'h1;
	endproperty
	a_mode4x: assert property (p_mode4x)
		else $error("4x mode does not give a 4 tick bit");

	property p_frame;
		(tx_st_q == ST_START |-> !tx_q) and
		(tx_st_q == ST_STOP |-> tx_q);
	endproperty
	a_frame: assert property (p_frame)
		else $error("start or stop level wrong on the line");

	property p_push;
		(fifo_en && tf_push && !tf_pop && !tf_clr) |=>
		tf_cnt == $past(tf_cnt) + CW'(1);
	endproperty
	a_push: assert property (p_push)
		else $error("data write did not add to transmit fifo");

	property p_temt;
		lsr_v[6] |-> tf_cnt == CW'(0) && tx_st_q == ST_IDLE && tx_q;
	endproperty
	a_temt: assert property (p_temt)
		else $error("shifter empty flag wrong");

	property p_false;
		(rx_st_q == ST_START && samp_tick_in && rx_cnt_q == hlast &&
		rx_s_q) |=> rx_st_q == ST_IDLE;
	endproperty
	a_false: assert property (p_false)
		else $error("false start bit was accepted");

	property p_rtsoff;
		(arts && rf_cnt >= CW'(RTS_HI[rsel])) |=> rts_n_out;
	endproperty
	a_rtsoff: assert property (p_rtsoff)
		else $error("rts not driven high at upper threshold");

	property p_cts;
		(tx_st_q == ST_IDLE && cfg_q.efeat[EFEAT_ACTS] && cts_s_q)
		|=> tx_st_q == ST_IDLE;
	endproperty
	a_cts: assert property (p_cts)
		else $error("transmitter started while cts high");

	property p_rtsint;
		($rose(rts_n_out) && cfg_q.ien[IEN_RTS] &&
		cfg_q.efeat[EFEAT_ENH]) |-> ##[0:1] isr_v[5];
	endproperty
	a_rtsint: assert property (p_rtsint)
		else $error("rts rise did not set source bit 5");

	c_txchar: cover property (tx_st_q == ST_STOP ##1 tx_st_q == ST_IDLE);
	c_rxchar: cover property (rf_push);
	c_rtsoff: cover property ($rose(rts_n_out) && arts);
	c_timeout: cover property (to_hit);
endmodule // uaf_top

// >>> sim/uaf_remote.sv
/*
 uaf_remote: far-end uart, 8 data bits, no parity, one stop bit.
 assumes: bit period is bit_clks_in cycles of clk_in; line idles high.
*/
module uaf_remote (
	// system
	input wire logic clk_in,
	input wire logic [5:0] bit_clks_in,
	// serial line
	input wire logic rts_n_in,
	input wire logic line_in,
	output logic line_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] tx_q[$];
	logic [7:0] rx_q[$];

	// ==========================================================
	// sender: looks at rts only between characters
	initial begin
		logic [9:0] f;
		line_out = 1'b1;
		forever begin
			@(posedge clk_in);
			if (tx_q.size() > 0 && rts_n_in === 1'b0) begin
				f = {1'b1, tx_q.pop_front(), 1'b0};
				for (int i = 0; i < 10; i++) begin
					line_out <= f[i];
					repeat (bit_clks_in) @(posedge clk_in);
				end
			end
		end
	end

	// ==========================================================
	// receiver: samples at mid-bit
	initial begin
		logic [7:0] b;
		forever begin
			@(negedge line_in);
			repeat (bit_clks_in / 2) @(posedge clk_in);
			for (int i = 0; i < 8; i++) begin
				repeat (bit_clks_in) @(posedge clk_in);
				b[i] = line_in;
			end
			repeat (bit_clks_in) @(posedge clk_in);
			rx_q.push_back(b);
		end
	end
endmodule // uaf_remote

// >>> sim/uaf_top_test.sv
/*
 uaf_top_test: self-checking bench for uaf_top with a far-end uart.
 assumes: sampling tick every second clock, 4x mode, so 8 clocks a bit, except t_mode: 8x, 16 clocks a bit.
*/
module uaf_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	import uaf_pkg::*;

	logic clk_in = 1'b0;
	logic rst_n_in;
	uaf_addr_type adr;
	logic rd, wr, tick, cts_n, tx, rts_n, irq, wait_rq;
	logic [31:0] wdata, rdata;
	logic rx;
	logic [5:0] bclk;
	int mismatches = 0;
	int samples_checked = 0;

	always #5 clk_in = !clk_in;

	always @(posedge clk_in) tick <= rst_n_in ? !tick : 1'b0;

	uaf_top dut_u (
		.clk_in(clk_in), .rst_n_in(rst_n_in),
		.avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
		.avs_writedata_in(wdata), .avs_byteenable_in(4'hF),
		.avs_readdata_out(rdata), .avs_waitrequest_out(wait_rq),
		.samp_tick_in(tick), .rx_in(rx), .cts_n_in(cts_n),
		.tx_out(tx), .rts_n_out(rts_n), .irq_out(irq)
	);

	uaf_remote rem_u (
		.clk_in(clk_in), .bit_clks_in(bclk), .rts_n_in(rts_n),
		.line_in(tx), .line_out(rx)
	);

	// ==========================================================
	// helpers
	task automatic final_report;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic fail(input string what);
		mismatches++;
		$display("[ERR] %s expected done got timeout", what);
		final_report;
	endtask

	task automatic chk(input string what, input logic [7:0] e,
		input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h got %h", what, e, g);
		end
	endtask

	// request held until waitrequest is sampled low
	task automatic bus(input logic w, input uaf_addr_type a,
		input logic [7:0] d, output logic [7:0] q);
		int n;
		n = 0;
		adr <= a;
		wr <= w;
		rd <= !w;
		wdata <= {24'h00_0000, d};
		do begin
			@(posedge clk_in);
			n++;
		end while (wait_rq !== 1'b0 && n < 50);
		if (n >= 50) fail("waitrequest");
		q = rdata[7:0];
		wr <= 1'b0;
		rd <= 1'b0;
		// idle edge: next call never re-raises a strobe in this step
		@(posedge clk_in);
	endtask

	task automatic wreg(input uaf_addr_type a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic wait_stat(input int b);
		logic [7:0] s;
		int n;
		n = 0;
		do begin
			bus(1'b0, ADR_LSTAT, 8'h00, s);
			n++;
		end while (s[b] !== 1'b1 && n < 2000);
		if (n >= 2000) fail("line_status");
	endtask

	task automatic wait_rem(input int c);
		int n;
		for (n = 0; n < 3000 && rem_u.rx_q.size() < c; n++)
			@(posedge clk_in);
		if (n >= 3000) fail("remote rx");
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset;
		logic [7:0] q;
		bus(1'b0, ADR_LSTAT, 8'h00, q);
		chk("line_status", 8'h60, q);
		bus(1'b0, 4'h9, 8'h00, q);
		chk("unmapped", 8'h00, q);
		chk("irq", 8'h00, {7'h00, irq});
	endtask

	task automatic t_tx;
		logic [7:0] q;
		logic [7:0] e[3] = '{8'hA5, 8'h3C, 8'h81};
		wreg(ADR_FCTL, 8'h01);
		wreg(ADR_LCTL, 8'h03);
		wreg(ADR_SMPL, 8'h20);
		foreach (e[i]) wreg(ADR_DATA, e[i]);
		wait_stat(6);
		wait_rem(3);
		foreach (e[i]) chk("serial", e[i], rem_u.rx_q.pop_front());
	endtask

	task automatic t_rx;
		logic [7:0] q;
		wreg(ADR_MCTL, 8'h02);
		wreg(ADR_IEN, 8'h01);
		rem_u.tx_q.push_back(8'h96);
		wait_stat(0);
		chk("irq", 8'h01, {7'h00, irq});
		bus(1'b0, ADR_DATA, 8'h00, q);
		chk("rx_holding", 8'h96, q);
		bus(1'b0, ADR_LSTAT, 8'h00, q);
		chk("line_status", 8'h60, q);
		chk("irq", 8'h00, {7'h00, irq});
		wreg(ADR_IEN, 8'h00);
	endtask

	task automatic t_rts;
		logic [7:0] q;
		int n;
		wreg(ADR_FCTL, 8'h41);
		wreg(ADR_EFEAT, 8'h50);
		wreg(ADR_IEN, 8'h40);
		wreg(ADR_MCTL, 8'h02);
		for (int i = 0; i < 12; i++) rem_u.tx_q.push_back(8'h10 + 8'(i));
		for (n = 0; n < 4000 && rts_n !== 1'b1; n++) @(posedge clk_in);
		if (n >= 4000) fail("rts rise");
		// fifo left unread so rts must stay off
		repeat (400) @(posedge clk_in);
		chk("rts_n", 8'h01, {7'h00, rts_n});
		chk("irq", 8'h01, {7'h00, irq});
		bus(1'b0, ADR_ISRC, 8'h00, q);
		chk("interrupt_source", 8'h20, q);
		for (int i = 0; i < 12; i++) begin
			wait_stat(0);
			bus(1'b0, ADR_DATA, 8'h00, q);
			chk("rx_holding", 8'h10 + 8'(i), q);
		end
		@(posedge clk_in);
		chk("rts_n", 8'h00, {7'h00, rts_n});
	endtask

	task automatic t_cts;
		logic [7:0] q;
		wreg(ADR_EFEAT, 8'h90);
		cts_n <= 1'b1;
		wreg(ADR_DATA, 8'h5A);
		repeat (300) @(posedge clk_in);
		chk("tx blocked", 8'h00, 8'(rem_u.rx_q.size()));
		bus(1'b0, ADR_LSTAT, 8'h00, q);
		chk("line_status", 8'h00, q & 8'h60);
		cts_n <= 1'b0;
		wait_rem(1);
		chk("serial", 8'h5A, rem_u.rx_q.pop_front());
	endtask

	// 8x sampling, 7 data bits, even parity
	task automatic t_mode;
		logic [7:0] q;
		wreg(ADR_SMPL, 8'h10);
		wreg(ADR_LCTL, 8'h1A);
		bclk <= 6'h10;
		wreg(ADR_DATA, 8'h43);
		wait_rem(1);
		chk("serial", 8'hC3, rem_u.rx_q.pop_front());
		rem_u.tx_q.push_back(8'hC1);
		wait_stat(0);
		bus(1'b0, ADR_LSTAT, 8'h00, q);
		chk("line_status", 8'h65, q);
		bus(1'b0, ADR_DATA, 8'h00, q);
		chk("rx_holding", 8'h41, q);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		rst_n_in = 1'b0;
		adr = ADR_DATA;
		rd = 1'b0;
		wr = 1'b0;
		wdata = 32'h0000_0000;
		bclk = 6'h08;
		cts_n = 1'b0;
		repeat (20) @(posedge clk_in);
		rst_n_in <= 1'b1;
		@(posedge clk_in);
		t_reset();
		t_tx();
		t_rx();
		t_rts();
		t_cts();
		t_mode();
		final_report;
	end
endmodule // uaf_top_test
